/* hdl/ets_pkg.sv */
// Package of constants and types for the exposure trigger sequencer
package ets_pkg;

  // Register byte offsets
  localparam logic [7:0] ETS_CTRL_OFS    = 8'h00;
  localparam logic [7:0] ETS_EXPT_OFS    = 8'h04;
  localparam logic [7:0] ETS_FINT_OFS    = 8'h08;
  localparam logic [7:0] ETS_ROUT_OFS    = 8'h0C;
  localparam logic [7:0] ETS_FCNT_OFS    = 8'h10;
  localparam logic [7:0] ETS_CMD_OFS     = 8'h14;
  localparam logic [7:0] ETS_STAT_OFS    = 8'h18;

  // Control field positions
  localparam int ETS_CTRL_MODE_LSB = 0;
  localparam int ETS_CTRL_POL_BIT  = 2;
  // Command field positions
  localparam int ETS_CMD_CAP_BIT   = 0;
  localparam int ETS_CMD_HALT_BIT  = 1;

  // Reset values
  localparam logic [1:0]  ETS_MODE_RST  = 2'h0;
  localparam logic        ETS_POL_RST   = 1'b0;
  localparam logic [31:0] ETS_EXPT_RST  = 32'h0000_0019;
  localparam logic [31:0] ETS_FINT_RST  = 32'h0000_0064;
  localparam logic [31:0] ETS_ROUT_RST  = 32'h0000_0032;
  localparam logic [15:0] ETS_FCNT_RST  = 16'h0001;

  // Input synchroniser depth
  localparam int ETS_SYNC_STAGES = 3;

  // External trigger mode select encoding
  typedef enum logic [1:0] {
    ETS_TRIG_NONE  = 2'h0,
    ETS_TRIG_STD   = 2'h1,
    ETS_TRIG_BULB  = 2'h2
  } ets_trig_e;

  // Sequencer states
  typedef enum logic [1:0] {
    ETS_IDLE,
    ETS_EXPOSE,
    ETS_READ,
    ETS_WAIT
  } ets_state_e;

endpackage

/* hdl/ets_trig_sync.sv */
// Three-stage trigger synchroniser with active-edge detection
`timescale 1ns/1ns
module ets_trig_sync
  import ets_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Trigger pin and polarity
  input  wire logic trig_pin,
  input  wire logic trigger_edge_select,
  // Qualified trigger
  output logic      trig_active,
  output logic      trig_start
);

  logic [ETS_SYNC_STAGES-1:0] sync_r;
  logic [ETS_SYNC_STAGES-1:0] sync_nxt;
  logic                       lvl_r;
  logic                       lvl_nxt;

  always_comb begin
    sync_nxt = {sync_r[ETS_SYNC_STAGES-2:0], trig_pin};
    // Level changes once stages two and three agree
    lvl_nxt  = (sync_r[1] == sync_r[2]) ? sync_r[2] : lvl_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= '1;
      lvl_r  <= 1'b1;
    end else begin
      sync_r <= sync_nxt;
      lvl_r  <= lvl_nxt;
    end
  end

  // Active level follows polarity; high selects rising edge
  assign trig_active = trigger_edge_select ? lvl_r : ~lvl_r; // RULE_15
  assign trig_start  = trigger_edge_select ? (lvl_nxt & ~lvl_r)
                                           : (~lvl_nxt & lvl_r); // RULE_15

endmodule

/* hdl/ets_seq.sv */
// Exposure trigger sequencer with APB register slave
// How it works
// RULE_01 - In streaming mode an exposure starts when the trigger reaches its active level.
// RULE_02 - Streaming exposures last the set time, are read out, and repeat each frame interval.
// RULE_03 - Once streaming has started, further triggers are ignored until a halt.
// RULE_04 - In single-shot mode an active trigger starts one preset exposure then its readout.
// RULE_05 - In single-shot mode triggers during readout are ignored.
// RULE_06 - After single-shot readout the sequencer idles until a new active trigger edge.
// RULE_07 - In bulb mode exposure runs from trigger active until trigger inactive.
// RULE_08 - In bulb mode triggers during readout of the prior exposure are ignored.
// RULE_09 - The exposure strobe output is high exactly while an exposure is active.
// RULE_10 - Trigger behaviour depends on no readout rate, binning, gain or offset setting.
// RULE_11 - With trigger mode none the trigger is ignored and capture takes the frame count.
// RULE_12 - Standard trigger with frame count zero or above one selects streaming mode.
// RULE_13 - Standard trigger with frame count exactly one selects single-shot mode.
// RULE_14 - Pulse-driven exposure selection gives bulb mode.
// RULE_15 - Polarity selects a rising or falling trigger edge to start exposure.
// RULE_16 - A halt aborts any sequence and returns to idle, ready for a new trigger.
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ns
module ets_seq
  import ets_pkg::*;
(
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // External trigger pin
  input  wire logic        ext_trigger,
  // Sensor timing
  output logic             exposure_strobe,
  output logic             readout_active
);

  // Registers
  logic [1:0]  mode_r, mode_nxt;
  logic        pol_r, pol_nxt;
  logic [31:0] expt_r, expt_nxt;
  logic [31:0] fint_r, fint_nxt;
  logic [31:0] rout_r, rout_nxt;
  logic [15:0] fcnt_r, fcnt_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pslverr_r, pslverr_nxt;
  // Sequencer
  ets_state_e  st_r, st_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic [31:0] frm_r, frm_nxt;
  logic [15:0] left_r, left_nxt;
  logic        stream_r, stream_nxt;
  logic        cap_r, cap_nxt;
  logic        strobe_r, strobe_nxt;
  logic        ro_r, ro_nxt;

  logic trig_active;
  logic trig_start;
  logic acc;
  logic wr;
  logic cap_cmd;
  logic halt_cmd;
  logic hw_std;
  logic hw_bulb;

  ets_trig_sync u_sync (
    .pclk                (pclk),
    .presetn             (presetn),
    .trig_pin            (ext_trigger),
    .trigger_edge_select (pol_r),
    .trig_active         (trig_active),
    .trig_start          (trig_start)
  );

  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign cap_cmd  = wr & (paddr == ETS_CMD_OFS) & pwdata[ETS_CMD_CAP_BIT];
  assign halt_cmd = wr & (paddr == ETS_CMD_OFS) & pwdata[ETS_CMD_HALT_BIT];
  assign hw_std   = (mode_r == ETS_TRIG_STD);
  assign hw_bulb  = (mode_r == ETS_TRIG_BULB); // RULE_14

  // Register file; no readout rate, binning, gain or offset input exists
  always_comb begin // RULE_10
    mode_nxt    = mode_r;
    pol_nxt     = pol_r;
    expt_nxt    = expt_r;
    fint_nxt    = fint_r;
    rout_nxt    = rout_r;
    fcnt_nxt    = fcnt_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    if (psel & ~penable) begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        ETS_CTRL_OFS: prdata_nxt = {29'h0, pol_r, mode_r};
        ETS_EXPT_OFS: prdata_nxt = expt_r;
        ETS_FINT_OFS: prdata_nxt = fint_r;
        ETS_ROUT_OFS: prdata_nxt = rout_r;
        ETS_FCNT_OFS: prdata_nxt = {16'h0, fcnt_r};
        ETS_CMD_OFS:  prdata_nxt = 32'h0000_0000;
        ETS_STAT_OFS: prdata_nxt = {left_r, 8'h0, 3'h0, stream_r,
                                    ro_r, strobe_r, 2'(st_r)};
        default:      pslverr_nxt = 1'b1;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        ETS_CTRL_OFS: begin
          mode_nxt = pwdata[ETS_CTRL_MODE_LSB +: 2];
          pol_nxt  = pwdata[ETS_CTRL_POL_BIT];
        end
        ETS_EXPT_OFS: expt_nxt = pwdata;
        ETS_FINT_OFS: fint_nxt = pwdata;
        ETS_ROUT_OFS: rout_nxt = pwdata;
        ETS_FCNT_OFS: fcnt_nxt = pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r    <= ETS_MODE_RST;
      pol_r     <= ETS_POL_RST;
      expt_r    <= ETS_EXPT_RST;
      fint_r    <= ETS_FINT_RST;
      rout_r    <= ETS_ROUT_RST;
      fcnt_r    <= ETS_FCNT_RST;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      mode_r    <= mode_nxt;
      pol_r     <= pol_nxt;
      expt_r    <= expt_nxt;
      fint_r    <= fint_nxt;
      rout_r    <= rout_nxt;
      fcnt_r    <= fcnt_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign pready  = 1'b1;

  // Sequencer next state
  always_comb begin
    st_nxt     = st_r;
    tmr_nxt    = tmr_r;
    frm_nxt    = (frm_r != 32'h0) ? frm_r - 32'h1 : frm_r;
    left_nxt   = left_r;
    stream_nxt = stream_r;
    cap_nxt    = cap_r;
    if (tmr_r != 32'h0) begin
      tmr_nxt = tmr_r - 32'h1;
    end
    unique case (st_r)
      ETS_IDLE: begin
        stream_nxt = 1'b0;
        cap_nxt    = 1'b0;
        if (hw_std & trig_start) begin // RULE_01 RULE_04 RULE_06
          st_nxt     = ETS_EXPOSE;
          tmr_nxt    = expt_r;
          frm_nxt    = fint_r;
          stream_nxt = (fcnt_r != 16'h1); // RULE_12 RULE_13
        end else if (hw_bulb & trig_start) begin // RULE_07
          st_nxt = ETS_EXPOSE;
        end else if ((mode_r == ETS_TRIG_NONE) & cap_cmd) begin // RULE_11
          st_nxt   = ETS_EXPOSE;
          tmr_nxt  = expt_r;
          frm_nxt  = fint_r;
          left_nxt = fcnt_r;
          cap_nxt  = 1'b1;
        end
      end
      ETS_EXPOSE: begin
        if (hw_bulb & ~cap_r) begin
          if (~trig_active) begin // RULE_07
            st_nxt  = ETS_READ;
            tmr_nxt = rout_r;
          end
        end else if (tmr_r <= 32'h1) begin // RULE_02 RULE_04
          st_nxt  = ETS_READ;
          tmr_nxt = rout_r;
        end
      end
      ETS_READ: begin
        // Trigger is not examined here
        if (tmr_r <= 32'h1) begin // RULE_05 RULE_08
          if (cap_r & (left_r == 16'h1)) begin
            st_nxt = ETS_IDLE;
          end else if (stream_r | cap_r) begin // RULE_02 RULE_03
            st_nxt = ETS_WAIT;
          end else begin
            st_nxt = ETS_IDLE; // RULE_06
          end
          if (cap_r & (left_r != 16'h0)) begin
            left_nxt = left_r - 16'h1;
          end
        end
      end
      ETS_WAIT: begin
        if (frm_r <= 32'h1) begin // RULE_02 RULE_03
          st_nxt  = ETS_EXPOSE;
          tmr_nxt = expt_r;
          frm_nxt = fint_r;
        end
      end
    endcase
    if (halt_cmd) begin // RULE_16
      st_nxt     = ETS_IDLE;
      tmr_nxt    = 32'h0;
      stream_nxt = 1'b0;
      cap_nxt    = 1'b0;
    end
    strobe_nxt = (st_nxt == ETS_EXPOSE); // RULE_09
    ro_nxt     = (st_nxt == ETS_READ);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r     <= ETS_IDLE;
      tmr_r    <= 32'h0;
      frm_r    <= 32'h0;
      left_r   <= 16'h0;
      stream_r <= 1'b0;
      cap_r    <= 1'b0;
      strobe_r <= 1'b0;
      ro_r     <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      tmr_r    <= tmr_nxt;
      frm_r    <= frm_nxt;
      left_r   <= left_nxt;
      stream_r <= stream_nxt;
      cap_r    <= cap_nxt;
      strobe_r <= strobe_nxt;
      ro_r     <= ro_nxt;
    end
  end

  assign exposure_strobe = strobe_r;
  assign readout_active  = ro_r;

  // Assertions
  sequence seq_std_start;
    (st_r == ETS_IDLE) && hw_std && trig_start && !halt_cmd;
  endsequence

  strobe_tracks_state_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    exposure_strobe == (st_r == ETS_EXPOSE))
    else $error("strobe differs from exposure state");

  std_trig_start_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    seq_std_start |=> exposure_strobe)
    else $error("standard trigger did not start exposure");

  expose_time_a: assert property (@(posedge pclk) disable iff (!presetn || halt_cmd) // RULE_02
    seq_std_start ##0 (expt_r == 32'h6) |=> exposure_strobe[*6] ##1 !exposure_strobe)
    else $error("exposure length wrong");

  read_ignores_trig_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
    (st_r == ETS_READ) && (tmr_r > 32'h1) && !halt_cmd |=> st_r == ETS_READ)
    else $error("readout disturbed by trigger");

  stream_no_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
    (st_r == ETS_WAIT) && stream_r && !halt_cmd && (frm_r > 32'h1) |=> st_r == ETS_WAIT)
    else $error("streaming wait left early");

  mode_select_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
    seq_std_start |=> stream_r == ($past(fcnt_r) != 16'h1))
    else $error("wrong streaming selection");

  single_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
    (st_r == ETS_READ) && !stream_r && !cap_r && (tmr_r <= 32'h1) |=> st_r == ETS_IDLE)
    else $error("single shot did not return idle");

  bulb_end_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    (st_r == ETS_EXPOSE) && hw_bulb && !cap_r && !trig_active && !halt_cmd |=> readout_active)
    else $error("bulb exposure did not end");

  halt_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_16
    halt_cmd |=> (st_r == ETS_IDLE) && !exposure_strobe && !readout_active)
    else $error("halt did not return idle");

  none_ignores_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
    (st_r == ETS_IDLE) && (mode_r == ETS_TRIG_NONE) && !cap_cmd |=> st_r == ETS_IDLE)
    else $error("trigger acted in mode none");

  sequence seq_bulb_read;
    (st_r == ETS_READ) && hw_bulb && !cap_r && (tmr_r > 32'h1);
  endsequence

  bulb_read_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
    seq_bulb_read ##0 !halt_cmd |=> readout_active && !exposure_strobe)
    else $error("bulb readout disturbed by trigger");

  single_select_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
    seq_std_start ##0 (fcnt_r == 16'h1) |=> !stream_r)
    else $error("single shot not selected");

endmodule

/* bench/ets_trig_src.sv */
// External trigger source model driving the trigger pin
`timescale 1ns/1ns
module ets_trig_src (
  // Clock
  input  wire logic pclk,
  // Polarity the source is wired for
  input  wire logic act_high,
  // Trigger pin
  output logic      ext_trigger
);
  logic active_r = 1'b0;

  // Idle at the inactive level, active level during a pulse
  assign ext_trigger = active_r ? act_high : ~act_high;

  // Active pulse of n clock cycles
  task automatic pulse(input int n);
    @(posedge pclk);
    active_r <= 1'b1;
    repeat (n) @(posedge pclk);
    active_r <= 1'b0;
  endtask
endmodule

/* bench/tb_exposure_trigger_sequencer.sv */
// Self-checking testbench for the exposure trigger sequencer
`timescale 1ns/1ns
module tb_exposure_trigger_sequencer
  import ets_pkg::*;
;
  localparam int EXP = 6;
  localparam int RDT = 12;
  localparam int FIV = 40;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        ext_trigger, exposure_strobe, readout_active, act_high;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          error_cnt = 0, total_checks = 0, n_exp = 0, exp_len = 0, rd_len = 0;
  int          period = 0, cyc = 0, last_rise = 0, s_run = 0, r_run = 0, n0 = 0;

  ets_seq u_dut (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .ext_trigger     (ext_trigger),
    .exposure_strobe (exposure_strobe),
    .readout_active  (readout_active)
  );
  ets_trig_src u_src (
    .pclk        (pclk),
    .act_high    (act_high),
    .ext_trigger (ext_trigger)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Exposure and readout run lengths and frame spacing
  always @(negedge pclk) begin
    cyc++;
    if (exposure_strobe === 1'b1) begin
      if (s_run == 0) begin
        n_exp++;
        period = cyc - last_rise;
        last_rise = cyc;
      end
      s_run++;
    end else if (s_run != 0) begin
      exp_len = s_run;
      s_run = 0;
    end
    if (readout_active === 1'b1) r_run++;
    else if (r_run != 0) begin
      rd_len = r_run;
      r_run = 0;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(k < 50, 1'b1);
  endtask

  task automatic cfg(input logic [31:0] c, input logic [31:0] f);
    apb(1'b1, ETS_CTRL_OFS, c);
    apb(1'b1, ETS_FCNT_OFS, f);
  endtask

  task automatic wait_sig(input logic rd, input logic lvl);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while ((rd ? readout_active : exposure_strobe) !== lvl && k < 2000);
    chk(k < 2000, 1'b1);
  endtask

  task automatic t_regs;
    logic [7:0]  ofs [7];
    logic [31:0] rst [7];
    ofs = '{ETS_CTRL_OFS, ETS_EXPT_OFS, ETS_FINT_OFS, ETS_ROUT_OFS, ETS_FCNT_OFS,
            ETS_CMD_OFS, 8'h1C};
    rst = '{32'h0, ETS_EXPT_RST, ETS_FINT_RST, ETS_ROUT_RST, 32'(ETS_FCNT_RST),
            32'h0, 32'h0};
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(q, rst[i]);
      chk(e, i == 6);
    end
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    chk(e, 1'b1);
    apb(1'b1, ETS_EXPT_OFS, 32'(EXP));
    apb(1'b1, ETS_FINT_OFS, 32'(FIV));
    apb(1'b1, ETS_ROUT_OFS, 32'(RDT));
    apb(1'b0, ETS_ROUT_OFS, 32'h0);
    chk(q, 32'(RDT));
  endtask

  task automatic t_none;
    cfg(32'h0, 32'h2);
    n0 = n_exp;
    u_src.pulse(3);
    repeat (20) @(posedge pclk);
    chk(n_exp, n0);
    apb(1'b1, ETS_CMD_OFS, 32'h1);
    repeat (150) @(posedge pclk);
    chk(n_exp, n0 + 2);
    chk(exp_len, EXP);
  endtask

  task automatic t_single;
    cfg(32'h1, 32'h1);
    n0 = n_exp;
    u_src.pulse(2);
    wait_sig(1'b1, 1'b1);
    chk(exp_len, EXP);
    u_src.pulse(2);
    wait_sig(1'b1, 1'b0);
    chk(rd_len, RDT);
    repeat (20) @(posedge pclk);
    chk(n_exp, n0 + 1);
    u_src.pulse(2);
    wait_sig(1'b1, 1'b1);
    chk(n_exp, n0 + 2);
    wait_sig(1'b1, 1'b0);
  endtask

  task automatic t_stream;
    cfg(32'h1, 32'h0);
    u_src.pulse(2);
    wait_sig(1'b0, 1'b1);
    apb(1'b0, ETS_STAT_OFS, 32'h0);
    chk(q, 32'h0000_0015);
    for (int i = 0; i < 3; i++) begin
      wait_sig(1'b0, 1'b0);
      wait_sig(1'b1, 1'b0);
      u_src.pulse(2);
      wait_sig(1'b0, 1'b1);
      chk(period, FIV);
      chk(rd_len, RDT);
    end
    apb(1'b1, ETS_CMD_OFS, 32'h2);
    repeat (2) @(posedge pclk);
    chk({exposure_strobe, readout_active}, 2'b00);
    n0 = n_exp;
    repeat (80) @(posedge pclk);
    chk(n_exp, n0);
  endtask

  task automatic t_bulb;
    cfg(32'h2, 32'h1);
    u_src.pulse(15);
    wait_sig(1'b1, 1'b1);
    chk(exp_len inside {15, 16}, 1'b1);
    n0 = n_exp;
    u_src.pulse(2);
    wait_sig(1'b1, 1'b0);
    repeat (20) @(posedge pclk);
    chk(n_exp, n0);
  endtask

  task automatic t_pol;
    cfg(32'h0, 32'h1);
    act_high <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b1, ETS_CTRL_OFS, 32'h5);
    n0 = n_exp;
    u_src.pulse(30);
    chk(exp_len, EXP);
    repeat (20) @(posedge pclk);
    chk(n_exp, n0 + 1);
  endtask

  task automatic stop_test;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    stop_test();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    act_high = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_none();
    t_single();
    t_stream();
    t_bulb();
    t_pol();
    stop_test();
  end
endmodule
